// [csp_params.svh]
// Constants of the discrete control and status port: timing, offsets, fields.
// Assumes a 40 MHz core clock; included by the package and the design modules.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// ==========================================================================
// Timing
`define CSP_CLOCK_KHZ        40000
`define CSP_TICK_MS          1
`define CSP_TICK_CYCLES      (`CSP_CLOCK_KHZ * `CSP_TICK_MS)
`define CSP_PULSE_MS         200
`define CSP_PULSE_TICKS      (`CSP_PULSE_MS / `CSP_TICK_MS)
`define CSP_STAB_MIN         15
`define CSP_STAB_TICKS       (`CSP_STAB_MIN * 60000 / `CSP_TICK_MS)

// ==========================================================================
// Widths
`define CSP_TICK_W           16
`define CSP_PULSE_W          8
`define CSP_STAB_W           20
`define CSP_ADDR_W           8
`define CSP_DATA_W           32
`define CSP_VALUE_W          16
`define CSP_PINS             8
`define CSP_PULSES           5
`define CSP_LIMITS           4

// ==========================================================================
// Pin channel indices
`define CSP_PIN_FULL_CAL     0
`define CSP_PIN_ZERO         1
`define CSP_PIN_OFFSET       2
`define CSP_PIN_TUNE         3
`define CSP_PIN_FAST_EXT     4
`define CSP_PIN_REF_LEAK     5
`define CSP_PIN_RANGE        6
`define CSP_PIN_REMOTE       7

// ==========================================================================
// Register map (byte addresses)
`define CSP_REG_CONTROL      8'h00
`define CSP_REG_STATUS       8'h04
`define CSP_REG_THRESHOLD0   8'h10
`define CSP_REG_THRESHOLD1   8'h14
`define CSP_REG_THRESHOLD2   8'h18
`define CSP_REG_THRESHOLD3   8'h1C

// Control fields
`define CSP_CTL_ZERO_ALLOW   0
`define CSP_CTL_RESET        1'h1
// Threshold fields: value in [15:0], source select in bit 16
`define CSP_THR_SRC_BIT      16
`define CSP_THR_RESET        17'h0FFFF

`endif

// [csp_pkg.sv]
// Types of the discrete control and status port.
// Assumes csp_params.svh is reachable on the include path.
`include "csp_params.svh"

package csp_pkg;

  typedef enum logic [1:0] {
    CSP_STARTUP,
    CSP_IDLE,
    CSP_RUN
  } csp_state_t;

  typedef enum logic [2:0] {
    CSP_R_NONE,
    CSP_R_FULL_CAL,
    CSP_R_ZERO,
    CSP_R_OFFSET,
    CSP_R_TUNE,
    CSP_R_FAST_EXT,
    CSP_R_REF_READ
  } csp_routine_t;

  typedef struct packed {
    logic [`CSP_PINS-1:0]                        s1;
    logic [`CSP_PINS-1:0]                        s2;
    logic [`CSP_PINS-1:0]                        s3;
    logic [`CSP_PINS-1:0]                        level;
    logic [`CSP_PULSES-1:0][`CSP_PULSE_W-1:0]    cnt;
    logic [`CSP_PULSES-1:0]                      fired;
    logic [`CSP_PULSES-1:0]                      fire;
  } csp_qual_t;

  typedef struct packed {
    logic [`CSP_TICK_W-1:0]                      tick_cnt;
    logic                                        tick;
    logic                                        prev_ref;
    csp_state_t                                  state;
    csp_routine_t                                kind;
    logic [`CSP_STAB_W-1:0]                      stab_cnt;
    logic                                        tune_ok;
    logic                                        int_ok;
    logic                                        ext_ok;
    logic                                        emitter;
    logic [1:0]                                  fil_fault;
    logic                                        ready;
    logic                                        busy;
    logic [`CSP_LIMITS-1:0]                      limit;
    logic                                        manual_range;
    logic                                        start;
    csp_routine_t                                code;
    logic                                        zero_allow;
    logic [`CSP_LIMITS-1:0][`CSP_VALUE_W:0]      thr;
    logic [`CSP_DATA_W-1:0]                      rdata;
  } csp_core_t;

endpackage

// [csp_pin_if.sv]
// Carrier between the pin qualifier and the port core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`include "csp_params.svh"

interface csp_pin_if;
  logic                   tick;
  logic [`CSP_PINS-1:0]   level;
  logic [`CSP_PULSES-1:0] fire;

  modport qual (input tick, output level, output fire);
  modport core (output tick, input level, input fire);
endinterface

// [csp_pin_qualifier.sv]
// Synchronises the command pins and qualifies the pulse commands by width.
// Assumes pins are asynchronous and tick is a one-cycle millisecond enable.
`timescale 1ns/10ps
`include "csp_params.svh"

module csp_pin_qualifier
  import csp_pkg::*;
#(
  parameter int unsigned PULSE_TICKS = `CSP_PULSE_TICKS
) (
  input  wire logic                 clock,   // Core clock
  input  wire logic                 reset,   // Async reset, active high
  input  wire logic [`CSP_PINS-1:0] pins,    // Raw command pins
  csp_pin_if.qual                   bus      // Qualified levels and pulses
);

  csp_qual_t st;
  csp_qual_t next_st;

  // ========================================================================
  // Three-stage sync, width count
  always_comb begin
    next_st      = st;
    next_st.s1   = pins;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.fire = '0;
    for (int i = 0; i < `CSP_PINS; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
    for (int i = 0; i < `CSP_PULSES; i++) begin
      if (!st.level[i]) begin
        next_st.cnt[i]   = '0;
        next_st.fired[i] = 1'b0;
      end else if (bus.tick && !st.fired[i]) begin
        // Fire once after more than the minimum width of ticks
        if (st.cnt[i] == `CSP_PULSE_W'(PULSE_TICKS)) begin
          next_st.fire[i]  = 1'b1;
          next_st.fired[i] = 1'b1;
        end else begin
          next_st.cnt[i] = st.cnt[i] + `CSP_PULSE_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.level = st.level;
  assign bus.fire  = st.fire;

endmodule

// [csp_port.sv]
// Discrete control and status port of a helium leak-test instrument.
// Assumes a 40 MHz clock; instrument core signals share that clock,
// command pins are asynchronous and are qualified by csp_pin_qualifier.
`timescale 1ns/10ps
`include "csp_params.svh"

module csp_port
  import csp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CSP_TICK_CYCLES,
  parameter int unsigned PULSE_TICKS = `CSP_PULSE_TICKS,
  parameter int unsigned STAB_TICKS  = `CSP_STAB_TICKS
) (
  input  wire logic                    clock,                 // Core clock, 40 MHz
  input  wire logic                    reset,                 // Async reset, active high
  // Register port
  input  wire logic [`CSP_ADDR_W-1:0]  address,               // Byte address
  input  wire logic [`CSP_DATA_W-1:0]  write_data,            // Write data
  input  wire logic                    write_strobe,          // Write, one cycle
  input  wire logic                    read_strobe,           // Read, one cycle
  output logic      [`CSP_DATA_W-1:0]  read_data,             // Read data, next cycle
  // Command pins
  input  wire logic                    full_cal_pin,          // Full internal calibration
  input  wire logic                    zero_pin,              // Background zeroing
  input  wire logic                    offset_pin,            // Zero-reference offset
  input  wire logic                    tune_pin,              // Tuning
  input  wire logic                    fast_ext_cal_pin,      // Fast external calibration
  input  wire logic                    reference_leak_read_request, // Standard leak on
  input  wire logic                    range_select_pin,      // High for manual ranging
  input  wire logic                    remote_select_pin,     // High for remote control
  // Front panel, same clock
  input  wire logic [5:0]              panel_command,         // Pulses, pin order
  input  wire logic                    panel_manual_range,    // Panel range choice
  // Instrument core, same clock
  input  wire logic                    routine_done,          // Routine finished, pulse
  input  wire logic                    routine_pass,          // Routine result
  input  wire logic                    emission_ok,           // Active filament emits
  input  wire logic                    filament_two_active,   // Filament two in use
  input  wire logic [1:0]              filament_burnt,        // Per-filament burn-out
  input  wire logic                    turbo_ok,              // Turbo pump healthy
  input  wire logic                    gauge_ok,              // Pressure gauge healthy
  input  wire logic                    startup_checks_ok,     // Startup limits met
  input  wire logic [`CSP_VALUE_W-1:0] leak_rate,             // Measured leak rate
  input  wire logic [`CSP_VALUE_W-1:0] port_pressure,         // Test-port pressure
  // Status outputs
  output logic                         tune_ok,               // Latest tune passed
  output logic                         internal_cal_ok,       // Internal cal good
  output logic                         external_cal_ok,       // External cal good
  output logic                         active_emitter,        // Low fil one, high two
  output logic      [1:0]              filament_fault,        // Per-filament fault
  output logic                         ready,                 // Ready for test
  output logic                         busy,                  // Not testing
  output logic                         limit_exceeded_one,    // Threshold one over
  output logic                         limit_exceeded_two,    // Threshold two over
  output logic                         limit_exceeded_three,  // Threshold three over
  output logic                         limit_exceeded_four,   // Threshold four over
  output logic                         manual_range,          // Manual ranging chosen
  output logic                         routine_start,         // Start pulse to core
  output csp_routine_t                 routine_code           // Routine to start
);

  csp_core_t  st;
  csp_core_t  next_st;
  csp_pin_if  pin_bus ();

  logic [`CSP_PINS-1:0] pins;
  assign pins = {remote_select_pin, range_select_pin, reference_leak_read_request,
                 fast_ext_cal_pin, tune_pin, offset_pin, zero_pin, full_cal_pin};

  // ========================================================================
  // Pin qualification
  csp_pin_qualifier #(
    .PULSE_TICKS (PULSE_TICKS)
  ) u_qualifier (
    .clock (clock),
    .reset (reset),
    .pins  (pins),
    .bus   (pin_bus.qual)
  );

  assign pin_bus.tick = st.tick;

  // ========================================================================
  // Next state
  logic                 remote;
  logic                 ref_rise;
  logic [5:0]           request;
  logic [`CSP_VALUE_W-1:0] source;

  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;
    next_st.rdata = '0;
    remote        = pin_bus.level[`CSP_PIN_REMOTE];
    ref_rise      = pin_bus.level[`CSP_PIN_REF_LEAK] && !st.prev_ref;
    source        = '0;
    next_st.prev_ref = pin_bus.level[`CSP_PIN_REF_LEAK];

    // Millisecond enable
    if (st.tick_cnt == `CSP_TICK_W'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + `CSP_TICK_W'(1);
      next_st.tick     = 1'b0;
    end

    // Command source selection
    if (remote) begin
      request = {ref_rise, pin_bus.fire};
    end else begin
      request = panel_command;
    end
    if (!st.zero_allow) begin
      request[`CSP_PIN_ZERO] = 1'b0;
    end
    next_st.manual_range = remote ? pin_bus.level[`CSP_PIN_RANGE] : panel_manual_range;

    case (st.state)
      CSP_STARTUP: begin
        if (st.tick) begin
          next_st.stab_cnt = st.stab_cnt + `CSP_STAB_W'(1);
        end
        if (startup_checks_ok || (st.stab_cnt == `CSP_STAB_W'(STAB_TICKS))) begin
          next_st.state = CSP_IDLE;
        end
      end
      CSP_IDLE: begin
        // One command at a time, calibration first
        next_st.start = 1'b1;
        if (request[`CSP_PIN_FULL_CAL]) begin
          next_st.code = CSP_R_FULL_CAL;
        end else if (request[`CSP_PIN_FAST_EXT]) begin
          next_st.code = CSP_R_FAST_EXT;
        end else if (request[`CSP_PIN_OFFSET]) begin
          next_st.code = CSP_R_OFFSET;
        end else if (request[`CSP_PIN_TUNE]) begin
          next_st.code = CSP_R_TUNE;
        end else if (request[`CSP_PIN_ZERO]) begin
          next_st.code = CSP_R_ZERO;
        end else if (request[`CSP_PIN_REF_LEAK]) begin
          next_st.code = CSP_R_REF_READ;
        end else begin
          next_st.start = 1'b0;
        end
        if (next_st.start) begin
          next_st.kind  = next_st.code;
          next_st.state = CSP_RUN;
        end
      end
      CSP_RUN: begin
        // Requests here are dropped
        if (routine_done) begin
          next_st.state = CSP_IDLE;
          case (st.kind)
            CSP_R_TUNE:     next_st.tune_ok = routine_pass;
            CSP_R_FULL_CAL: next_st.int_ok  = routine_pass;
            CSP_R_FAST_EXT: next_st.ext_ok  = routine_pass;
            default:        next_st.kind    = st.kind;
          endcase
          next_st.kind = CSP_R_NONE;
        end
      end
      default: begin
        next_st.state = CSP_STARTUP;
      end
    endcase

    if (!emission_ok) begin
      next_st.int_ok = 1'b0;
      next_st.ext_ok = 1'b0;
    end

    next_st.emitter   = filament_two_active;
    next_st.fil_fault = filament_burnt;
    next_st.busy      = (next_st.state != CSP_IDLE);
    next_st.ready     = !next_st.busy && emission_ok && turbo_ok && gauge_ok
                        && !filament_burnt[filament_two_active]
                        && (next_st.int_ok || next_st.ext_ok);

    for (int i = 0; i < `CSP_LIMITS; i++) begin
      source = st.thr[i][`CSP_THR_SRC_BIT] ? port_pressure : leak_rate;
      next_st.limit[i] = (source > st.thr[i][`CSP_VALUE_W-1:0]);
    end

    // Register port
    if (write_strobe) begin
      case (address)
        `CSP_REG_CONTROL:    next_st.zero_allow = write_data[`CSP_CTL_ZERO_ALLOW];
        `CSP_REG_THRESHOLD0: next_st.thr[0] = write_data[`CSP_VALUE_W:0];
        `CSP_REG_THRESHOLD1: next_st.thr[1] = write_data[`CSP_VALUE_W:0];
        `CSP_REG_THRESHOLD2: next_st.thr[2] = write_data[`CSP_VALUE_W:0];
        `CSP_REG_THRESHOLD3: next_st.thr[3] = write_data[`CSP_VALUE_W:0];
        default:             next_st.zero_allow = st.zero_allow;
      endcase
    end
    if (read_strobe) begin
      case (address)
        `CSP_REG_CONTROL:    next_st.rdata = {31'h0, st.zero_allow};
        `CSP_REG_STATUS:     next_st.rdata = {8'h00, pin_bus.level, 2'h0, remote,
                                              st.manual_range, st.limit, st.busy,
                                              st.ready, st.fil_fault, st.emitter,
                                              st.ext_ok, st.int_ok, st.tune_ok};
        `CSP_REG_THRESHOLD0: next_st.rdata = {15'h0, st.thr[0]};
        `CSP_REG_THRESHOLD1: next_st.rdata = {15'h0, st.thr[1]};
        `CSP_REG_THRESHOLD2: next_st.rdata = {15'h0, st.thr[2]};
        `CSP_REG_THRESHOLD3: next_st.rdata = {15'h0, st.thr[3]};
        default:             next_st.rdata = '0;
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st            <= '0;
      st.state      <= CSP_STARTUP;
      st.kind       <= CSP_R_NONE;
      st.code       <= CSP_R_NONE;
      st.busy       <= 1'b1;
      st.zero_allow <= `CSP_CTL_RESET;
      st.thr        <= {`CSP_LIMITS{`CSP_THR_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs
  assign read_data            = st.rdata;
  assign tune_ok              = st.tune_ok;
  assign internal_cal_ok      = st.int_ok;
  assign external_cal_ok      = st.ext_ok;
  assign active_emitter       = st.emitter;
  assign filament_fault       = st.fil_fault;
  assign ready                = st.ready;
  assign busy                 = st.busy;
  assign limit_exceeded_one   = st.limit[0];
  assign limit_exceeded_two   = st.limit[1];
  assign limit_exceeded_three = st.limit[2];
  assign limit_exceeded_four  = st.limit[3];
  assign manual_range         = st.manual_range;
  assign routine_start        = st.start;
  assign routine_code         = st.code;

endmodule

// [csp_port_chk.sv]
// Concurrent checks on the control and status port outputs.
// Assumes binding into csp_port; one clock domain, async reset.
`timescale 1ns/10ps
module csp_port_chk
  import csp_pkg::*;
(
  input wire logic         clock,               // Core clock
  input wire logic         reset,               // Async reset
  input wire logic         routine_start,       // Start pulse
  input wire csp_routine_t routine_code,        // Routine code
  input wire logic         routine_done,        // Core done
  input wire logic         routine_pass,        // Core result
  input wire logic         busy,                // Busy output
  input wire logic         ready,               // Ready output
  input wire logic         tune_ok,             // Tune result
  input wire logic         internal_cal_ok,     // Internal cal
  input wire logic         external_cal_ok,     // External cal
  input wire logic         emission_ok,         // Emission level
  input wire logic         turbo_ok,            // Pump health
  input wire logic         gauge_ok,            // Gauge health
  input wire logic         filament_two_active, // Filament choice
  input wire logic         active_emitter,      // Emitter output
  input wire logic [1:0]   filament_burnt,      // Burn-out levels
  input wire logic [1:0]   filament_fault,      // Fault outputs
  input wire logic         remote_select_pin,   // Remote pin
  input wire logic         panel_manual_range,  // Panel range
  input wire logic         manual_range         // Range output
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ======
  // Sequences
  sequence s_launch;
    routine_start;
  endsequence
  sequence s_wait;
    !routine_done [*4];
  endsequence
  // ======
  // Assertions
  AST_START_ONCE: assert property (routine_start |=> !routine_start)
    else $error("start pulse too long");
  AST_START_BUSY: assert property (routine_start |-> busy)
    else $error("start without busy");
  AST_NO_RESTART: assert property ($past(busy) && busy |-> !routine_start)
    else $error("start while busy");
  AST_BUSY_HOLD: assert property (s_launch ##1 s_wait |-> busy)
    else $error("busy dropped early");
  AST_EMITTER: assert property (!$past(reset) |-> active_emitter == $past(filament_two_active))
    else $error("emitter wrong");
  AST_FAULT: assert property (!$past(reset) |-> filament_fault == $past(filament_burnt))
    else $error("fault wrong");
  AST_EMISSION: assert property (!emission_ok |=> !internal_cal_ok && !external_cal_ok)
    else $error("cal good without emission");
  AST_READY: assert property (!$past(reset) && ready |->
    !busy && $past(emission_ok && turbo_ok && gauge_ok)) else $error("ready wrong");
  AST_STARTUP: assert property ($fell(reset) |-> (busy && !ready) [*2])
    else $error("startup state wrong");
  AST_TUNE: assert property (busy && routine_done && routine_code == CSP_R_TUNE |=>
    tune_ok == $past(routine_pass)) else $error("tune result wrong");
  AST_LOCAL_RANGE: assert property (!remote_select_pin [*6] |=>
    manual_range == $past(panel_manual_range)) else $error("panel range ignored");
endmodule

bind csp_port csp_port_chk u_chk (.*);

// [csp_ctrl_model.sv]
// Model of the external controller that drives the command pins.
// Assumes the bench calls its tasks just after clock edges.
`timescale 1ns/10ps
module csp_ctrl_model (
  input  wire logic       clock,      // Core clock
  output logic      [7:0] pins,       // Command pin levels
  output logic            valve_open  // Test valve state
);
  initial begin
    pins = 8'h00;
    valve_open = 1'b0;
  end
  // ======
  // Pulse held for the whole width
  task automatic press(input int i, input int n, input logic open);
    @(posedge clock);
    valve_open <= open;
    pins[i] <= 1'b1;
    repeat (n) @(posedge clock);
    pins[i] <= 1'b0;
    @(posedge clock);
  endtask
  task automatic set(input int i, input logic v);
    @(posedge clock);
    pins[i] <= v;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench of the control and status port.
// Assumes shortened counts: 4 cycles a tick, 3 ticks a pulse, 20 ticks startup.
`timescale 1ns/10ps
module testbench;
  import csp_pkg::*;
  typedef struct packed {
    logic [2:0]   pin;
    csp_routine_t code;
    logic         pass;
    logic [3:0]   flags;
  } csp_row_t;
  logic clock, reset, write_strobe, read_strobe, routine_done, routine_pass, emission_ok;
  logic filament_two_active, turbo_ok, gauge_ok, startup_checks_ok, panel_manual_range;
  logic tune_ok, internal_cal_ok, external_cal_ok, active_emitter, ready, busy, manual_range;
  logic limit_exceeded_one, limit_exceeded_two, limit_exceeded_three, limit_exceeded_four;
  logic routine_start, valve_open;
  logic [7:0]   address, pins;
  logic [31:0]  write_data, read_data, v;
  logic [5:0]   panel_command;
  logic [1:0]   filament_burnt, filament_fault;
  logic [15:0]  leak_rate, port_pressure;
  csp_routine_t routine_code;
  int num_errors, n_tests, n_start, dcnt, dly, s;
  csp_row_t rows [8] = '{'{3'h0, CSP_R_FULL_CAL, 1'b1, 4'h5}, '{3'h3, CSP_R_TUNE, 1'b0, 4'h5},
    '{3'h3, CSP_R_TUNE, 1'b1, 4'hD}, '{3'h2, CSP_R_OFFSET, 1'b1, 4'hD},
    '{3'h4, CSP_R_FAST_EXT, 1'b1, 4'hF}, '{3'h1, CSP_R_ZERO, 1'b1, 4'hF},
    '{3'h5, CSP_R_REF_READ, 1'b1, 4'hF}, '{3'h0, CSP_R_FULL_CAL, 1'b0, 4'hB}};

  csp_ctrl_model ctrl (.clock(clock), .pins(pins), .valve_open(valve_open));
  csp_port #(.TICK_CYCLES(4), .PULSE_TICKS(3), .STAB_TICKS(20)) dut (.*,
    .full_cal_pin(pins[0]), .zero_pin(pins[1]), .offset_pin(pins[2]), .tune_pin(pins[3]),
    .fast_ext_cal_pin(pins[4]), .reference_leak_read_request(pins[5]),
    .range_select_pin(pins[6]), .remote_select_pin(pins[7]));

  // ======
  // Clock, core responder, watchdog
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    routine_done <= 1'b0;
    if (routine_start === 1'b1) begin
      n_start++;
      dcnt = dly;
    end else if (dcnt > 0) begin
      dcnt--;
      if (dcnt == 0) routine_done <= 1'b1;
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    give_verdict();
  end

  // ======
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 chk(read_data, exp, "read data");
  endtask
  task automatic run(input int i, input int n, input logic hit, input csp_routine_t c);
    s = n_start;
    ctrl.press(i, n, i == 4);
    repeat (60) @(posedge clock);
    chk(n_start - s, hit, "start count");
    if (hit) chk(routine_code, c, "routine code");
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ======
  // Main sequence
  initial begin
    {reset, emission_ok, turbo_ok, gauge_ok} = 4'hF;
    {write_strobe, read_strobe, routine_pass, startup_checks_ok} = 4'h0;
    {filament_two_active, panel_manual_range, routine_done} = 3'h0;
    {address, write_data, panel_command, filament_burnt} = '0;
    {leak_rate, port_pressure, dcnt, n_start, num_errors, n_tests} = '0;
    dly = 8;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    #1 chk({busy, ready}, 2'h2, "startup outputs");
    rd(8'h00, 32'h0000_0001);
    rd(8'h10, 32'h0000_FFFF);
    rd(8'h08, 32'h0000_0000);
    repeat (30) @(posedge clock);
    chk(busy, 1'b1, "busy during startup");
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clock);
    chk({busy, ready}, 2'h0, "startup end");
    $display("test startup done");
    ctrl.set(7, 1'b1);
    foreach (rows[k]) begin
      @(posedge clock);
      routine_pass <= rows[k].pass;
      run(rows[k].pin, 40, 1'b1, rows[k].code);
      chk({tune_ok, internal_cal_ok, external_cal_ok, ready}, rows[k].flags, "flags");
    end
    $display("test commands done");
    rd(8'h04, 32'h0080_2045);
    run(3, 8, 1'b0, CSP_R_NONE);
    wr(8'h00, 32'h0);
    run(1, 40, 1'b0, CSP_R_NONE);
    wr(8'h00, 32'h1);
    run(1, 40, 1'b1, CSP_R_ZERO);
    dly = 200;
    s = n_start;
    ctrl.press(0, 40, 1'b0);
    ctrl.press(3, 40, 1'b0);
    repeat (250) @(posedge clock);
    chk(n_start - s, 1, "restart while busy");
    chk(routine_code, CSP_R_FULL_CAL, "code while busy");
    dly = 8;
    $display("test refusals done");
    ctrl.set(7, 1'b0);
    panel_manual_range <= 1'b1;
    repeat (10) @(posedge clock);
    chk(manual_range, 1'b1, "panel range");
    run(3, 40, 1'b0, CSP_R_NONE);
    s = n_start;
    panel_command <= 6'h08;
    @(posedge clock);
    panel_command <= 6'h00;
    repeat (40) @(posedge clock);
    chk({n_start - s, routine_code}, {32'h1, CSP_R_TUNE}, "panel tune");
    ctrl.set(7, 1'b1);
    ctrl.set(6, 1'b1);
    repeat (10) @(posedge clock);
    chk(manual_range, 1'b1, "manual range");
    ctrl.set(6, 1'b0);
    repeat (10) @(posedge clock);
    chk(manual_range, 1'b0, "auto range");
    $display("test remote done");
    wr(8'h10, 32'h0000_0100);
    leak_rate <= 16'h0101;
    repeat (3) @(posedge clock);
    chk(limit_exceeded_one, 1'b1, "limit over");
    leak_rate <= 16'h0100;
    wr(8'h14, 32'h0001_0010);
    port_pressure <= 16'h0011;
    repeat (3) @(posedge clock);
    chk({limit_exceeded_four, limit_exceeded_three, limit_exceeded_two, limit_exceeded_one},
        4'h2, "limits");
    filament_two_active <= 1'b1;
    filament_burnt <= 2'h2;
    repeat (3) @(posedge clock);
    chk({active_emitter, filament_fault, ready}, 4'hC, "filaments");
    emission_ok <= 1'b0;
    repeat (3) @(posedge clock);
    chk({internal_cal_ok, external_cal_ok}, 2'h0, "no emission");
    $display("test status done");
    give_verdict();
  end
endmodule
